//--- gpio_pud_dat.sv
// AHB-Lite slave for the port B pullup control and the port A pin data register
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
module gpio_pud_dat #(
  parameter int QUAL_SAMPLES = gpio_pud_dat_pkg::QUAL_SAMPLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [31:0] port_a_pin_in,
  output logic [31:0] port_a_pin_out,
  output logic [31:0] port_a_pin_oe,
  output logic [6:0] port_b_pullup_en
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [6:0] pud_r;
  logic [6:0] pud_nxt;
  logic [31:0] latch_r;
  logic [31:0] latch_nxt;
  logic [31:0] fsel_r;
  logic [31:0] fsel_nxt;
  logic [31:0] dir_r;
  logic [31:0] dir_nxt;
  logic gate_r;
  logic gate_nxt;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  gpio_pud_dat_pkg::wr_pend_t wr_r;
  gpio_pud_dat_pkg::pin_drive_t drive_r;
  logic [6:0] pullup_en_r;
  logic [31:0] qual_level;

  // ------------------------------------------------------------
  // Address phase decode
  // ------------------------------------------------------------
  wire addr_phase = hsel & hready & (htrans == gpio_pud_dat_pkg::HTRANS_NONSEQ);
  wire word_access = (hsize == gpio_pud_dat_pkg::HSIZE_WORD);
  wire in_block = (haddr[31:5] == 27'h0000000) & (haddr[1:0] == 2'h0);
  wire [11:0] ofs = haddr[11:0];
  wire [4:0] sel_now = !in_block ? 5'h00 :
    (ofs == gpio_pud_dat_pkg::PORT_B_PULLUP_DISABLE_OFS) ? gpio_pud_dat_pkg::REG_PUD :
    (ofs == gpio_pud_dat_pkg::PORT_A_PIN_DATA_OFS) ? gpio_pud_dat_pkg::REG_DAT :
    (ofs == gpio_pud_dat_pkg::PROTECTED_WRITE_GATE_OFS) ? gpio_pud_dat_pkg::REG_GATE :
    (ofs == gpio_pud_dat_pkg::PORT_A_FUNCTION_SELECT_OFS) ? gpio_pud_dat_pkg::REG_FSEL :
    (ofs == gpio_pud_dat_pkg::PORT_A_DIRECTION_OFS) ? gpio_pud_dat_pkg::REG_DIR : 5'h00;
  wire rd_now = addr_phase & ~hwrite;
  wire wr_now = addr_phase & hwrite & word_access;

  // ------------------------------------------------------------
  // Data phase write strobes
  // ------------------------------------------------------------
  // Narrow writes are dropped; the whole word is the only unit here
  wire wr_pud = wr_r.valid & (wr_r.sel == gpio_pud_dat_pkg::REG_PUD);
  wire wr_dat = wr_r.valid & (wr_r.sel == gpio_pud_dat_pkg::REG_DAT);
  wire wr_gate = wr_r.valid & (wr_r.sel == gpio_pud_dat_pkg::REG_GATE);
  wire wr_fsel = wr_r.valid & (wr_r.sel == gpio_pud_dat_pkg::REG_FSEL);
  wire wr_dir = wr_r.valid & (wr_r.sel == gpio_pud_dat_pkg::REG_DIR);
  wire gate_open = gate_r;

  // Configuration writes pass only through an open gate
  assign pud_nxt = (wr_pud & gate_open) ? hwdata[6:0] : pud_r;
  assign fsel_nxt = (wr_fsel & gate_open) ? hwdata : fsel_r;
  assign dir_nxt = (wr_dir & gate_open) ? hwdata : dir_r;
  assign gate_nxt = wr_gate ? hwdata[gpio_pud_dat_pkg::GATE_OPEN_BIT] : gate_r;
  // Latch takes every write, whatever the pin's mode
  assign latch_nxt = wr_dat ? hwdata : latch_r;

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  // Uses next values (pin data excepted, it reads qual_level) so a read right behind a write sees the new data
  wire [31:0] rd_mux =
    (sel_now == gpio_pud_dat_pkg::REG_PUD) ? {25'h0000000, pud_nxt} :
    (sel_now == gpio_pud_dat_pkg::REG_DAT) ? qual_level :
    (sel_now == gpio_pud_dat_pkg::REG_GATE) ? {31'h00000000, gate_nxt} :
    (sel_now == gpio_pud_dat_pkg::REG_FSEL) ? fsel_nxt :
    (sel_now == gpio_pud_dat_pkg::REG_DIR) ? dir_nxt : gpio_pud_dat_pkg::UNMAPPED_READ;

  // ------------------------------------------------------------
  // Pin outputs
  // ------------------------------------------------------------
  // Driven only in general-purpose mode with direction set to output
  wire [31:0] oe_nxt = ~fsel_r & dir_r;

  // ------------------------------------------------------------
  // Input qualification, one per pin
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < gpio_pud_dat_pkg::PORT_A_PINS; gi++) begin : g_qual
      pin_qualifier #(
        .SAMPLES(QUAL_SAMPLES)
      ) u_qual (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(port_a_pin_in[gi]),
        .qual_r(qual_level[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Bus side flops
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= '0;
      hrdata_r <= gpio_pud_dat_pkg::UNMAPPED_READ;
      hreadyout_r <= 1'b1;
    end else begin
      wr_r.valid <= wr_now;
      wr_r.sel <= sel_now;
      hreadyout_r <= 1'b1;
      if (rd_now) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pud_r <= gpio_pud_dat_pkg::PULLUP_DISABLE_RST;
      latch_r <= gpio_pud_dat_pkg::PIN_LATCH_RST;
      fsel_r <= gpio_pud_dat_pkg::FUNCTION_SELECT_RST;
      dir_r <= gpio_pud_dat_pkg::DIRECTION_RST;
      gate_r <= gpio_pud_dat_pkg::GATE_RST;
    end else begin
      pud_r <= pud_nxt;
      latch_r <= latch_nxt;
      fsel_r <= fsel_nxt;
      dir_r <= dir_nxt;
      gate_r <= gate_nxt;
    end
  end

  // ------------------------------------------------------------
  // Pin side flops
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_r <= '0;
      pullup_en_r <= ~gpio_pud_dat_pkg::PULLUP_DISABLE_RST;
    end else begin
      drive_r.level <= latch_r;
      drive_r.enable <= oe_nxt;
      pullup_en_r <= ~pud_r;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = gpio_pud_dat_pkg::HRESP_OKAY;
  assign port_a_pin_out = drive_r.level;
  assign port_a_pin_oe = drive_r.enable;
  assign port_b_pullup_en = pullup_en_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic rd_dat_dp;
  logic rd_pud_dp;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dat_dp <= 1'b0;
      rd_pud_dp <= 1'b0;
    end else begin
      rd_dat_dp <= rd_now & (sel_now == gpio_pud_dat_pkg::REG_DAT);
      rd_pud_dp <= rd_now & (sel_now == gpio_pud_dat_pkg::REG_PUD);
    end
  end

  pullup_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pud & gate_open) |-> ##2 (port_b_pullup_en == ~$past(hwdata[6:0], 2)))
    else $error("pullup enable does not follow written disable bits");

  gate_closed_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pud & ~gate_open) |=> (pud_r == $past(pud_r)))
    else $error("pullup disable changed while gate closed");

  read_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_dat_dp |-> (hrdata == $past(qual_level)))
    else $error("pin data read is not the qualified pin level");

  drive_enable_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 (port_a_pin_oe == ($past(~fsel_r) & $past(dir_r))))
    else $error("output enable does not match mode and direction");

  drive_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_dat |-> ##2 (port_a_pin_out == $past(hwdata, 2)))
    else $error("pin level does not follow written data");

  latch_store_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_dat |=> (latch_r == $past(hwdata)))
    else $error("written data not stored in output latch");

  latch_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ~wr_dat |=> $stable(latch_r))
    else $error("output latch changed without a write");

  pud_reserved_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pud_dp |-> (hrdata[31:7] == 25'h0000000))
    else $error("reserved pullup disable bits read nonzero");

  // ------------------------------------------------------------
  // Bus protocol checks
  // ------------------------------------------------------------
  hresp_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (hresp == gpio_pud_dat_pkg::HRESP_OKAY))
    else $error("response is not OKAY");

  ready_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout)
    else $error("ready dropped although no wait states exist");

  wr_track_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 (wr_r.valid == $past(wr_now)))
    else $error("pending write does not follow the address phase");

  narrow_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_phase & hwrite & ~word_access)
    |=> ~wr_r.valid)
    else $error("narrow write was not dropped");

  unmapped_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_now & (sel_now == 5'h00))
    |=> (hrdata == gpio_pud_dat_pkg::UNMAPPED_READ))
    else $error("unmapped read returned nonzero data");

  // Read data must stand until the next read is taken
  rd_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ~rd_now
    |=> $stable(hrdata))
    else $error("read data changed without a read");

  // ------------------------------------------------------------
  // Configuration register checks
  // ------------------------------------------------------------
  pud_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ~wr_pud
    |=> $stable(pud_r))
    else $error("pullup disable changed without a write");

  pullup_track_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 (port_b_pullup_en == ~$past(pud_r)))
    else $error("pullup enable is not the inverse of the disable bits");

  fsel_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_fsel & ~gate_open)
    |=> $stable(fsel_r))
    else $error("function select changed while gate closed");

  dir_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_dir & ~gate_open)
    |=> $stable(dir_r))
    else $error("direction changed while gate closed");

  fsel_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_fsel & gate_open)
    |=> (fsel_r == $past(hwdata)))
    else $error("function select write was lost");

  dir_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_dir & gate_open)
    |=> (dir_r == $past(hwdata)))
    else $error("direction write was lost");

  // Gate itself is never protected, or it could not be opened
  gate_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_gate
    |=> (gate_r == $past(hwdata[gpio_pud_dat_pkg::GATE_OPEN_BIT])))
    else $error("gate write was lost");

  gate_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ~wr_gate
    |=> $stable(gate_r))
    else $error("gate changed without a write");

  // ------------------------------------------------------------
  // Output latch checks
  // ------------------------------------------------------------
  // Cycles since the last data write, saturating
  logic [7:0] since_dat_wr_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_dat_wr_r <= 8'h00;
    end else if (wr_dat) begin
      since_dat_wr_r <= 8'h00;
    end else if (since_dat_wr_r != 8'hFF) begin
      since_dat_wr_r <= since_dat_wr_r + 8'h01;
    end
  end

  out_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 (port_a_pin_out == $past(latch_r)))
    else $error("pin level does not follow the output latch");

  latch_settled_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (since_dat_wr_r > 8'h02)
    |-> (port_a_pin_out == latch_r))
    else $error("pin level drifted from a held latch");

  pud_write_c: cover property (@(posedge hclk) disable iff (!hresetn) wr_pud & gate_open);
  pud_blocked_c: cover property (@(posedge hclk) disable iff (!hresetn) wr_pud & ~gate_open);
  dat_read_c: cover property (@(posedge hclk) disable iff (!hresetn) rd_dat_dp);
  latch_only_c: cover property (@(posedge hclk) disable iff (!hresetn) wr_dat & ~(|oe_nxt));
  narrow_drop_c: cover property (@(posedge hclk) disable iff (!hresetn) addr_phase & hwrite & ~word_access);

endmodule

//--- gpio_pud_dat_pkg.sv
// Constants, types and the behaviour list for the pullup and pin data block
//
// Behaviour
// - Port B pullup bits 6..0: 0 enables pullup, 1 disables it; reset to 0.
// - Pullup disable writes take effect only while the protected write gate is open.
// - Reading pin data returns each pin's qualified level, whatever its configuration.
// - Written 0/1 drives the pin low/high when it is a general-purpose output.
// - A write to a non-output pin's bit still lands in the output latch.
// - Each output latch bit holds until software writes pin data again.
// - Reset clears every output latch bit to zero.
// - Pin data reads return qualified pin levels, never the output latch.
// - Pin data read value right after reset is 0 (QUAL_LEVEL_RST), then follows the external pin levels once qualified.
// - Pin data bit n maps one-to-one onto port A pin n, bits 31..0.
package gpio_pud_dat_pkg;

  // ------------------------------------------------------------
  // Register map (byte offsets)
  // ------------------------------------------------------------
  localparam logic [11:0] PORT_B_PULLUP_DISABLE_OFS = 12'h000;
  localparam logic [11:0] PORT_A_PIN_DATA_OFS = 12'h004;
  localparam logic [11:0] PROTECTED_WRITE_GATE_OFS = 12'h008;
  localparam logic [11:0] PORT_A_FUNCTION_SELECT_OFS = 12'h00C;
  localparam logic [11:0] PORT_A_DIRECTION_OFS = 12'h010;

  // ------------------------------------------------------------
  // Widths, fields and reset values
  // ------------------------------------------------------------
  localparam int PORT_A_PINS = 32;
  localparam int PORT_B_PINS = 7;
  localparam int GATE_OPEN_BIT = 0;
  localparam logic [6:0] PULLUP_DISABLE_RST = 7'h00;
  localparam logic [31:0] PIN_LATCH_RST = 32'h0000_0000;
  localparam logic [31:0] FUNCTION_SELECT_RST = 32'h0000_0000;
  localparam logic [31:0] DIRECTION_RST = 32'h0000_0000;
  localparam logic GATE_RST = 1'b0;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ------------------------------------------------------------
  // Input qualification
  // ------------------------------------------------------------
  localparam int QUAL_SAMPLES = 3;
  localparam logic QUAL_LEVEL_RST = 1'b0;

  // ------------------------------------------------------------
  // Bus encodings
  // ------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    REG_PUD = 5'b00001,
    REG_DAT = 5'b00010,
    REG_GATE = 5'b00100,
    REG_FSEL = 5'b01000,
    REG_DIR = 5'b10000
  } reg_sel_t;

  // Write captured in the address phase, performed in the data phase
  typedef struct packed {
    logic valid;
    logic [4:0] sel;
  } wr_pend_t;

  // Drive of one port: level and enable
  typedef struct packed {
    logic [31:0] level;
    logic [31:0] enable;
  } pin_drive_t;

endpackage

//--- gpio_pud_dat_tb.sv
// Self-checking bench for the pullup and pin data block
`timescale 1ns/10ps
module gpio_pud_dat_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_dp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, pin_in, pin_out, pin_oe, ext, v, e, fs, dr, oe;
  logic [6:0] pu_en;
  logic [31:0] exp_q[$];
  int fail_count, n_compared;
  localparam logic [31:0] A_PUD = {20'h00000, gpio_pud_dat_pkg::PORT_B_PULLUP_DISABLE_OFS};
  localparam logic [31:0] A_DAT = {20'h00000, gpio_pud_dat_pkg::PORT_A_PIN_DATA_OFS};
  localparam logic [31:0] A_GATE = {20'h00000, gpio_pud_dat_pkg::PROTECTED_WRITE_GATE_OFS};
  localparam logic [31:0] A_FSEL = {20'h00000, gpio_pud_dat_pkg::PORT_A_FUNCTION_SELECT_OFS};
  localparam logic [31:0] A_DIR = {20'h00000, gpio_pud_dat_pkg::PORT_A_DIRECTION_OFS};

  gpio_pud_dat DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .port_a_pin_in(pin_in), .port_a_pin_out(pin_out),
    .port_a_pin_oe(pin_oe), .port_b_pullup_en(pu_en));
  pin_world PINS (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_level(pin_in));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task report_and_stop;
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Slave may stretch a phase; never assume zero waits
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      report_and_stop;
    end
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= ~w;
    wait_rdy;
    rd_dp <= 1'b0;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rd(input logic [31:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  task done(input string s);
    $display("test %s done", s);
  endtask

  // Read data are compared in the data phase, oldest note first
  always @(posedge hclk) begin
    if (rd_dp === 1'b1 && hreadyout === 1'b1 && exp_q.size() > 0)
      chk(hrdata, exp_q.pop_front());
    if (rd_dp === 1'b1 && hreadyout === 1'b1)
      chk({31'h0, hresp}, 32'h0);
  end

  initial begin
    repeat (20000) @(posedge hclk);
    $display("timeout");
    fail_count++;
    report_and_stop;
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ext = 32'h0;
    rd_dp = 1'b0;
    fail_count = 0;
    n_compared = 0;
    v = $urandom(84);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({25'h0, pu_en}, 32'h0000_007F);
    chk(pin_out, 32'h0);
    rd(A_PUD, 32'h0);
    done("reset");
    wr(A_PUD, 32'hFFFF_FFFF);
    rd(A_PUD, 32'h0);
    wr(A_GATE, 32'h1);
    v = $urandom;
    wr(A_PUD, v | 32'hFFFF_FF80);
    rd(A_PUD, {25'h0, v[6:0]});
    repeat (3) @(posedge hclk);
    chk({25'h0, pu_en}, {25'h0, ~v[6:0]});
    wr(A_GATE, 32'h0);
    wr(A_PUD, 32'h0);
    rd(A_PUD, {25'h0, v[6:0]});
    done("pullup");
    e = $urandom;
    ext <= e;
    v = $urandom;
    wr(A_DAT, v);
    repeat (6) @(posedge hclk);
    chk(pin_out, v);
    chk(pin_oe, 32'h0);
    // Data reads return the board levels, not the written latch, while no pin is an output
    rd(A_DAT, e);
    for (int n = 0; n < 32; n += 7) begin
      ext <= 32'h1 << n;
      repeat (6) @(posedge hclk);
      rd(A_DAT, 32'h1 << n);
    end
    done("latch");
    wr(A_GATE, 32'h1);
    fs = $urandom;
    dr = $urandom;
    oe = ~fs & dr;
    wr(A_FSEL, fs);
    wr(A_DIR, dr);
    repeat (6) @(posedge hclk);
    chk(pin_oe, oe);
    chk(pin_out, v);
    rd(A_DAT, (oe & v) | (~oe & ext));
    wr(A_DAT, ~v);
    repeat (6) @(posedge hclk);
    chk(pin_out, ~v);
    rd(A_DAT, (oe & ~v) | (~oe & ext));
    hsize <= 3'h0;
    wr(A_DAT, v);
    hsize <= 3'h2;
    repeat (3) @(posedge hclk);
    chk(pin_out, ~v);
    wr(32'h0000_0014, 32'hFFFF_FFFF);
    rd(32'h0000_0014, 32'h0);
    chk(pin_out, ~v);
    done("drive");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(pin_out, 32'h0);
    chk(pin_oe, 32'h0);
    rd(A_PUD, 32'h0);
    repeat (6) @(posedge hclk);
    rd(A_DAT, ext);
    done("second reset");
    repeat (3) @(posedge hclk);
    report_and_stop;
  end
endmodule

//--- pin_qualifier.sv
// One pin's input qualifier: level changes after a run of equal samples
`timescale 1ns/10ps
module pin_qualifier #(
  parameter int SAMPLES = gpio_pud_dat_pkg::QUAL_SAMPLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_in,
  output logic qual_r
);

  logic [SAMPLES-1:0] hist_r;
  wire all_high = &hist_r;
  wire all_low = ~(|hist_r);

  // ------------------------------------------------------------
  // Sample history
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hist_r <= '0;
    end else begin
      hist_r <= {hist_r[SAMPLES-2:0], pin_in};
    end
  end

  // ------------------------------------------------------------
  // Qualified level
  // ------------------------------------------------------------
  // Settles to the true pin level within SAMPLES+1 edges of release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qual_r <= gpio_pud_dat_pkg::QUAL_LEVEL_RST;
    end else if (all_high) begin
      qual_r <= 1'b1;
    end else if (all_low) begin
      qual_r <= 1'b0;
    end
  end

endmodule

//--- pin_world.sv
// Behavioural model of the port A pins and the board behind them
`timescale 1ns/10ps
module pin_world (
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] ext_level,
  output logic [31:0] pin_level
);
  // Driven bits follow the device, the rest follow the board
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
